// >>> asf_pkg.sv
// package for the alu status flag block: opcodes, bit positions, register offsets
package asf_pkg;
    // flag bit positions in the condition register
    localparam int ASF_BIT_C  = 0;
    localparam int ASF_BIT_HC = 1;
    localparam int ASF_BIT_Z  = 2;
    localparam int ASF_BIT_SW = 3;
    localparam int ASF_BIT_N  = 4;
    localparam logic [7:0] ASF_IMPL_MASK = 8'h1f;
    // register offsets on the software port
    localparam logic [3:0] ASF_OFF_FLAGS  = 4'h0;
    localparam logic [3:0] ASF_OFF_RESULT = 4'h1;
    localparam logic [3:0] ASF_OFF_IRQ_ST = 4'h2;
    localparam logic [3:0] ASF_OFF_IRQ_MK = 4'h3;
    localparam logic [7:0] ASF_RST_FLAGS  = 8'h00;
    localparam logic [7:0] ASF_RST_RESULT = 8'h00;
    localparam logic [4:0] ASF_RST_IRQ    = 5'h00;
    // interrupt status bits: one per flag, set when the flag rises
    localparam int ASF_IRQ_W = 5;
    // operations driven by the core sequencer
    typedef enum logic [3:0] {
        ASF_OP_NONE,
        ASF_OP_ADD,      // add_accumulator_file_op / add_literal_op
        ASF_OP_SUB,      // subtract_accumulator_file_op / subtract_from_literal_op
        ASF_OP_LOGIC,    // and of source and accumulator: z and n only
        ASF_OP_CLEAR,    // clear_file_op
        ASF_OP_ROT_L,    // rotate_left_op
        ASF_OP_ROT_R,    // rotate_right_op
        ASF_OP_BIT_CLR,  // bit_clear_op
        ASF_OP_BIT_SET,  // bit_set_op
        ASF_OP_SWAP,     // nibble_swap_op
        ASF_OP_MOVE      // file_to_file_move_op / accumulator_to_file_move_op
    } asf_op_t;
endpackage : asf_pkg

// >>> asf_flag_calc.sv
`timescale 1ns/100ps
// combinational flag and result generator for one alu operation
module asf_flag_calc (
    // operation and operands
    input  wire asf_pkg::asf_op_t op_in,
    input  wire logic [7:0]       src_in,
    input  wire logic [7:0]       acc_in,
    input  wire logic [2:0]       bit_sel_in,
    input  wire logic [7:0]       flags_in,
    // result and new flags
    output logic [7:0]            result_out,
    output logic [4:0]            flags_out
);
    import asf_pkg::*;

    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] addend;
    logic [7:0] bit_onehot;
    wire        is_sub;
    wire        is_arith;
    wire        carry_in;

    assign is_sub   = (op_in == ASF_OP_SUB);
    assign is_arith = (op_in == ASF_OP_ADD) || is_sub;
    // subtract adds the two's complement, so carry set means no borrow
    assign addend   = is_sub ? ~acc_in : acc_in;
    assign carry_in = is_sub;
    assign sum      = {1'b0, src_in} + {1'b0, addend} + {8'h00, carry_in};
    assign low_sum  = {1'b0, src_in[3:0]} + {1'b0, addend[3:0]} + {4'h0, carry_in};
    assign bit_onehot = 8'h01 << bit_sel_in;

    always_comb begin
        result_out = src_in;
        flags_out  = flags_in[4:0];
        case (op_in)
            ASF_OP_ADD, ASF_OP_SUB: begin
                result_out            = sum[7:0];
                flags_out[ASF_BIT_C]  = sum[8];
                flags_out[ASF_BIT_HC] = low_sum[4];
                flags_out[ASF_BIT_SW] = (src_in[7] == addend[7]) && (sum[7] != src_in[7]);
            end
            ASF_OP_LOGIC: result_out = src_in & acc_in;
            ASF_OP_CLEAR: result_out = 8'h00;
            ASF_OP_ROT_L: begin
                result_out            = {src_in[6:0], flags_in[ASF_BIT_C]};
                flags_out[ASF_BIT_C]  = src_in[7];
                flags_out[ASF_BIT_HC] = src_in[3];
            end
            ASF_OP_ROT_R: begin
                result_out            = {flags_in[ASF_BIT_C], src_in[7:1]};
                flags_out[ASF_BIT_C]  = src_in[0];
                flags_out[ASF_BIT_HC] = src_in[4];
            end
            ASF_OP_BIT_CLR: result_out = src_in & ~bit_onehot;
            ASF_OP_BIT_SET: result_out = src_in | bit_onehot;
            ASF_OP_SWAP:    result_out = {src_in[3:0], src_in[7:4]};
            ASF_OP_MOVE:    result_out = src_in;
            default:        result_out = src_in;
        endcase
        // z follows every arithmetic, logic, clear and rotate result; n follows all of them except clear
        if (is_arith || op_in == ASF_OP_LOGIC || op_in == ASF_OP_CLEAR ||
            op_in == ASF_OP_ROT_L || op_in == ASF_OP_ROT_R) begin
            flags_out[ASF_BIT_Z] = (result_out == 8'h00);
            // clear only sets z; n keeps its stored value
            if (op_in != ASF_OP_CLEAR) begin
                flags_out[ASF_BIT_N] = result_out[7];
            end
        end
    end
endmodule : asf_flag_calc

// >>> asf_status_flags.sv
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/100ps
// alu status flag register with instruction port, software port and interrupt
// Notes on behaviour
// - flag-affecting op aimed at status register drops result, updates flags only
// - clearing status register sets zero flag, leaves other flags alone
// - bit clear/set, nibble swap and moves touch flags only when aimed at the status register
// - bits 7 to 5 read zero; writes there are ignored
// - negative flag bit 4 copies result msb, except on clear
// - overflow flag bit 3 marks signed overflow into the sign bit
// - zero flag bit 2 set when result is zero
// - half carry bit 1 is carry out of bit 3 on add and subtract
// - carry bit 0 is carry out of msb on add and subtract
// - on subtract carry and half carry mean no borrow
// - subtract is addition of the two's complement
// - rotates load half carry from source bit 4 or bit 3
// - rotates load carry from the bit shifted out
// - status register works as a source like any register; as destination it stores only the results of ops that do not set flags
module asf_status_flags (
    // clock and reset
    input  wire logic             mclk_in,
    input  wire logic             sys_rst_in,
    // instruction port from the core sequencer
    input  wire logic             exec_in,
    input  wire asf_pkg::asf_op_t op_in,
    input  wire logic [7:0]       src_in,
    input  wire logic             src_is_status_in,
    input  wire logic [7:0]       acc_in,
    input  wire logic [2:0]       bit_sel_in,
    input  wire logic             dest_is_status_in,
    // software register port
    input  wire logic [3:0]       reg_addr_in,
    input  wire logic [7:0]       reg_wdata_in,
    input  wire logic             reg_wr_in,
    input  wire logic             reg_rd_in,
    output logic [7:0]            reg_rdata_out,
    // result and flags toward the datapath
    output logic [7:0]            result_out,
    output logic                  result_valid_out,
    output logic [7:0]            flags_out,
    output logic                  irq_out
);
    import asf_pkg::*;

    logic [7:0] flags;
    logic [7:0] result;
    logic       result_valid;
    logic [4:0] irq_status;
    logic [4:0] irq_mask;
    logic [7:0] rdata;
    logic       irq;
    logic [7:0] calc_result;
    logic [4:0] calc_flags;

    wire [7:0] status_view;
    wire [7:0] operand;
    wire       flag_op;
    wire       wr_flags;
    wire       wr_irq_st;
    wire       wr_irq_mk;
    wire [7:0] next_flags;
    wire [4:0] rise;
    wire [4:0] next_irq_status;
    wire [7:0] next_rdata;

    // unimplemented upper bits always read as zero
    assign status_view = flags & ASF_IMPL_MASK;
    // status register may be the source operand like any other register
    assign operand = src_is_status_in ? status_view : src_in;

    asf_flag_calc u_calc (
        .op_in      (op_in),
        .src_in     (operand),
        .acc_in     (acc_in),
        .bit_sel_in (bit_sel_in),
        .flags_in   (status_view),
        .result_out (calc_result),
        .flags_out  (calc_flags)
    );

    assign flag_op = (op_in == ASF_OP_ADD) || (op_in == ASF_OP_SUB) ||
                     (op_in == ASF_OP_LOGIC) || (op_in == ASF_OP_CLEAR) ||
                     (op_in == ASF_OP_ROT_L) || (op_in == ASF_OP_ROT_R);
    assign wr_flags  = reg_wr_in && reg_addr_in == ASF_OFF_FLAGS;
    assign wr_irq_st = reg_wr_in && reg_addr_in == ASF_OFF_IRQ_ST;
    assign wr_irq_mk = reg_wr_in && reg_addr_in == ASF_OFF_IRQ_MK;

    // flag ops to the status register keep only the new flags, so a clear
    // leaves zero set and the other flags at their stored values
    // non flag ops aimed at the status register store their result
    assign next_flags =
        (exec_in && flag_op)                       ? {3'b000, calc_flags} :
        (exec_in && dest_is_status_in)             ? (calc_result & ASF_IMPL_MASK) :
        wr_flags                                   ? (reg_wdata_in & ASF_IMPL_MASK) :
                                                     flags;

    // event: a flag going from clear to set
    assign rise = next_flags[4:0] & ~flags[4:0];
    // set beats the write-one clear in the same cycle
    assign next_irq_status = (irq_status & ~(wr_irq_st ? reg_wdata_in[4:0] : 5'h00)) | rise;

    assign next_rdata =
        (reg_addr_in == ASF_OFF_FLAGS)  ? status_view :
        (reg_addr_in == ASF_OFF_RESULT) ? result :
        (reg_addr_in == ASF_OFF_IRQ_ST) ? {3'b000, irq_status} :
        (reg_addr_in == ASF_OFF_IRQ_MK) ? {3'b000, irq_mask} :
                                          8'h00;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            flags        <= ASF_RST_FLAGS;
            result       <= ASF_RST_RESULT;
            result_valid <= 1'b0;
            irq_status   <= ASF_RST_IRQ;
            irq_mask     <= ASF_RST_IRQ;
            rdata        <= 8'h00;
            irq          <= 1'b0;
        end else begin
            flags        <= next_flags;
            // result discarded when a flag op targets the status register
            result_valid <= exec_in && !(flag_op && dest_is_status_in);
            if (exec_in && !(flag_op && dest_is_status_in)) begin
                result <= calc_result;
            end
            irq_status   <= next_irq_status;
            if (wr_irq_mk) begin
                irq_mask <= reg_wdata_in[4:0];
            end
            rdata        <= reg_rd_in ? next_rdata : 8'h00;
            irq          <= |(next_irq_status & (wr_irq_mk ? reg_wdata_in[4:0] : irq_mask));
        end
    end

    assign reg_rdata_out    = rdata;
    assign result_out       = result;
    assign result_valid_out = result_valid;
    assign flags_out        = flags;
    assign irq_out          = irq;
endmodule : asf_status_flags

// >>> asf_status_flags_assertions.sv
// assertion checker for the alu status flag block
`timescale 1ns/100ps
module asf_status_flags_chk import asf_pkg::*; (
    // clock and reset
    input wire logic             mclk_in,
    input wire logic             sys_rst_in,
    // instruction port
    input wire logic             exec_in,
    input wire asf_pkg::asf_op_t op_in,
    input wire logic [7:0]       src_in,
    input wire logic [7:0]       acc_in,
    input wire logic             src_is_status_in,
    input wire logic             dest_is_status_in,
    // outputs watched
    input wire logic [7:0]       result_out,
    input wire logic             result_valid_out,
    input wire logic [7:0]       flags_out
);
    // flag ops that rewrite z, and n except on clear
    wire logic fop = exec_in && op_in inside {ASF_OP_ADD, ASF_OP_SUB, ASF_OP_LOGIC, ASF_OP_CLEAR, ASF_OP_ROT_L,
                                             ASF_OP_ROT_R};
    wire logic own = !src_is_status_in && !dest_is_status_in;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    a_rsvd_zero: assert property (flags_out[7:5] == 3'h0) else $error("upper bits set");
    a_dest_discard: assert property (fop && dest_is_status_in |=> !result_valid_out) else $error("result kept");
    a_clear_zero: assert property (exec_in && op_in == ASF_OP_CLEAR |=>
        flags_out[4:0] == (($past(flags_out[4:0]) & 5'h1b) | 5'h04)) else $error("clear flags wrong");
    a_noflag_hold: assert property (exec_in && !dest_is_status_in && op_in inside {ASF_OP_BIT_CLR,
        ASF_OP_BIT_SET, ASF_OP_SWAP, ASF_OP_MOVE} |=> $stable(flags_out)) else $error("flags moved");
    a_zero_neg: assert property (fop && own |=> flags_out[2] == (result_out == 8'h00)
        && flags_out[4] == ($past(op_in) == ASF_OP_CLEAR ? $past(flags_out[4]) : result_out[7]))
        else $error("z or n wrong");
    a_add_carry: assert property (exec_in && op_in == ASF_OP_ADD && own |=>
        flags_out[0] == ({1'b0, $past(src_in)} + $past(acc_in) > 9'h0ff)) else $error("add carry wrong");
    a_sub_borrow: assert property (exec_in && op_in == ASF_OP_SUB && own |=>
        flags_out[0] == ($past(src_in) >= $past(acc_in))) else $error("borrow wrong");
    a_rot_carry: assert property (exec_in && op_in == ASF_OP_ROT_L && own |=>
        flags_out[1:0] == {$past(src_in[3]), $past(src_in[7])}) else $error("rotate flags wrong");
endmodule : asf_status_flags_chk
bind asf_status_flags asf_status_flags_chk chk (.*);

// >>> alu_status_flag_logic_bench.sv
// self-checking bench for the alu status flag block
`timescale 1ns/100ps
module alu_status_flag_logic_bench;
    import asf_pkg::*;
    logic mclk_in = 0, sys_rst_in = 1, exec_in = 0, src_is_status_in = 0, dest_is_status_in = 0, seen = 0;
    logic reg_wr_in = 0, reg_rd_in = 0, result_valid_out, irq_out;
    asf_op_t op_in = ASF_OP_NONE, ro;
    logic [7:0] src_in = 0, acc_in = 0, reg_wdata_in = 0, reg_rdata_out, result_out, flags_out, ef = 0, er = 0, rs;
    logic [3:0] reg_addr_in = 0;
    logic [2:0] bit_sel_in = 0;
    logic [4:0] est = 0, em = 0;
    logic [17:0] q[$], v;
    int err_total = 0, num_checks = 0, cyc = 0, seed = 32'he28c;
    always #10 mclk_in = ~mclk_in;
    asf_status_flags dut (.*);
    task automatic check(logic [15:0] got, logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    // any rising flag latches its interrupt status bit
    task automatic newf(logic [7:0] f);
        est |= f[4:0] & ~ef[4:0];
        ef = f;
    endtask : newf
    task automatic strobe(logic e, logic w, logic r);
        @(posedge mclk_in);
        exec_in <= e;
        reg_wr_in <= w;
        reg_rd_in <= r;
    endtask : strobe
    task automatic reg_write(logic [3:0] a, logic [7:0] d);
        strobe(0, 1, 0);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        if (a == ASF_OFF_FLAGS) newf({3'h0, d[4:0]});
        if (a == ASF_OFF_IRQ_ST) est &= ~d[4:0];
        if (a == ASF_OFF_IRQ_MK) em = d[4:0];
    endtask : reg_write
    task automatic reg_read(logic [3:0] a);
        strobe(0, 0, 1);
        reg_addr_in <= a;
        q.push_back({10'h200, a == 0 ? ef : a == 1 ? er : a == 2 ? {3'h0, est} : a == 3 ? {3'h0, em} : 8'h00});
    endtask : reg_read
    task automatic irq_check();
        strobe(0, 0, 0);
        repeat (2) @(posedge mclk_in);
        @(negedge mclk_in);
        check({15'h0, irq_out}, {15'h0, |(est & em)});
    endtask : irq_check
    task automatic exec_op(asf_op_t o, logic [7:0] s, a, logic [2:0] b, logic ss, ds);
        logic [8:0] w;
        logic [4:0] h;
        logic [7:0] x, y, r, f;
        strobe(1, 0, 0);
        op_in <= o;
        src_in <= s;
        acc_in <= a;
        bit_sel_in <= b;
        src_is_status_in <= ss;
        dest_is_status_in <= ds;
        x = ss ? ef : s;
        f = ef;
        y = (o == ASF_OP_SUB) ? ~a : a;
        w = {1'b0, x} + y + (o == ASF_OP_SUB);
        h = x[3:0] + y[3:0] + (o == ASF_OP_SUB);
        case (o)
            ASF_OP_ADD, ASF_OP_SUB: begin
                r = w[7:0];
                f[3:0] = {x[7] == y[7] && r[7] != x[7], f[2], h[4], w[8]};
            end
            ASF_OP_LOGIC: r = x & a;
            ASF_OP_CLEAR: r = 8'h00;
            ASF_OP_ROT_L: r = {x[6:0], ef[0]};
            ASF_OP_ROT_R: r = {ef[0], x[7:1]};
            ASF_OP_BIT_CLR: r = x & ~(8'h01 << b);
            ASF_OP_BIT_SET: r = x | (8'h01 << b);
            ASF_OP_SWAP: r = {x[3:0], x[7:4]};
            default: r = x;
        endcase
        if (o == ASF_OP_ROT_L) f[1:0] = {x[3], x[7]};
        if (o == ASF_OP_ROT_R) f[1:0] = {x[4], x[0]};
        if (o inside {ASF_OP_BIT_CLR, ASF_OP_BIT_SET, ASF_OP_SWAP, ASF_OP_MOVE}) begin
            if (ds) newf({3'h0, r[4:0]});
            er = r;
        end else begin
            if (o != ASF_OP_CLEAR) f[4] = r[7];
            f[2] = r == 8'h00;
            newf(f);
            if (!ds) er = r;
        end
        q.push_back({1'b0, !ds || o inside {ASF_OP_BIT_CLR, ASF_OP_BIT_SET, ASF_OP_SWAP, ASF_OP_MOVE}, er, ef});
    endtask : exec_op
    always @(posedge mclk_in) begin
        seen <= exec_in | reg_rd_in;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            conclude();
        end
    end
    always @(negedge mclk_in) begin
        if (seen) begin
            v = q.pop_front();
            check(v[17] ? {8'h00, reg_rdata_out} : {result_out, flags_out}, v[15:0]);
            if (!v[17]) check({15'h0, result_valid_out}, {15'h0, v[16]});
        end
    end
    initial begin
        repeat (2) @(posedge mclk_in);
        sys_rst_in <= 0;
        reg_read(ASF_OFF_FLAGS);
        exec_op(ASF_OP_ADD, 8'h7f, 8'h01, 0, 0, 0);
        exec_op(ASF_OP_SUB, 8'h00, 8'h01, 0, 0, 0);
        reg_write(ASF_OFF_IRQ_MK, 8'h04);
        reg_write(ASF_OFF_FLAGS, 8'hff);
        exec_op(ASF_OP_CLEAR, 8'h55, 8'h00, 0, 0, 1);
        exec_op(ASF_OP_ADD, 8'h10, 8'h22, 0, 1, 0);
        for (int i = 0; i < 8; i++) reg_read(4'(i));
        irq_check();
        reg_write(ASF_OFF_IRQ_ST, 8'h1f);
        irq_check();
        // move result source is ambiguous, so both operands are made equal
        repeat (300) begin
            ro = asf_op_t'(4'($unsigned($random(seed)) % 10 + 1));
            rs = 8'($random(seed));
            exec_op(ro, rs, ro == ASF_OP_MOVE ? rs : 8'($random(seed)), 3'($random(seed)),
                    ro != ASF_OP_MOVE && $random(seed) % 8 == 0, $random(seed) % 4 == 0);
            if ($random(seed) % 3 == 0) reg_read(ASF_OFF_FLAGS);
        end
        irq_check();
        reg_write(ASF_OFF_IRQ_MK, 8'h00);
        irq_check();
        conclude();
    end
endmodule : alu_status_flag_logic_bench
